//--- bench/gpm_pin_model.sv
/* Eight pads of one port with an external driver and weak pull-ups.
   Undriven pins with neither board drive nor pull-up toggle each clock. */
`timescale 1ns/1ns
module gpm_pin_model
    import gpm_pkg::*;
(
    // Clock
    input  wire logic      clk,
    // Design and board side
    input  wire gpm_byte_t out,
    input  wire gpm_byte_t oe,
    input  wire gpm_byte_t pu,
    input  wire gpm_byte_t ext,
    input  wire gpm_byte_t ext_en,
    output wire gpm_byte_t pin
);
    gpm_byte_t tog_q = 8'h00;
    always @(posedge clk) tog_q <= ~tog_q;
    // Open-drain high is released to pull-up or board
    assign pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | tog_q));
endmodule // gpm_pin_model

//--- bench/gpm_port_io_props.sv
/* Concurrent checks on the ports of gpm_port_io.
   Assumes one clock, asynchronous active-high reset, registered outputs. */
`timescale 1ns/1ns
module gpm_port_io_props
    import gpm_pkg::*;
(
    // Clock and reset
    input wire logic      clk,
    input wire logic      rst,
    // Watched ports
    input wire gpm_addr_t sfr_addr,
    input wire logic      sfr_wr,
    input wire logic      sfr_rd,
    input wire gpm_byte_t sfr_rdata_q,
    input wire logic      xbar_enable,
    input wire gpm_byte_t p1_twowire,
    input wire gpm_byte_t p0_bypass_q,
    input wire gpm_byte_t p1_bypass_q,
    input wire gpm_byte_t p0_pin_oe_q,
    input wire gpm_byte_t p0_pullup_q,
    input wire gpm_byte_t p0_analog_q,
    input wire gpm_byte_t p1_pin_out_q,
    input wire gpm_byte_t p1_pin_oe_q,
    input wire gpm_byte_t p1_pullup_q,
    input wire gpm_byte_t p1_analog_q,
    input wire logic      match_interrupt_enable,
    input wire logic      match_irq_q,
    input wire logic      match_wake_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ************************************************************
    // Properties
    // ************************************************************
    property p_irq_wake; match_irq_q |-> match_wake_q; endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
    property p_irq_en; !$past(match_interrupt_enable) |-> !match_irq_q; endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
    property p_an1; (p1_analog_q & (p1_pin_oe_q | p1_pullup_q)) == 8'h00; endproperty
    a_an1: assert property (p_an1) else $error("p1 analog pin active");
    property p_an0; (p0_analog_q & (p0_pin_oe_q | p0_pullup_q)) == 8'h00; endproperty
    a_an0: assert property (p_an0) else $error("p0 analog pin active");
    property p_tw; ($past(p1_twowire) & p1_pin_oe_q & p1_pin_out_q) == 8'h00; endproperty
    a_tw: assert property (p_tw) else $error("two-wire pin driven high");
    property p_xoff; !$past(xbar_enable) |-> (p0_pin_oe_q | p1_pin_oe_q) == 8'h00; endproperty
    a_xoff: assert property (p_xoff) else $error("driver on, crossbar off");
    property p_byp0; $changed(p0_bypass_q) |-> $past(sfr_wr) && $past(sfr_addr) == 8'hd4;
    endproperty
    a_byp0: assert property (p_byp0) else $error("p0 bypass changed unwritten");
    property p_byp1; $changed(p1_bypass_q) |-> $past(sfr_wr) && $past(sfr_addr) == 8'hd5;
    endproperty
    a_byp1: assert property (p_byp1) else $error("p1 bypass changed unwritten");
    property p_rd; $changed(sfr_rdata_q) |-> $past(sfr_rd); endproperty
    a_rd: assert property (p_rd) else $error("read data changed unread");
    property p_rst; $past(rst) |-> p0_bypass_q == 8'h00 && p1_bypass_q == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("bypass not clear after reset");
endmodule // gpm_port_io_props
bind gpm_port_io gpm_port_io_props u_props (.*);

//--- bench/tb_top.sv
/* Random and corner tests of gpm_port_io through its register port and pins.
   Assumes the pin model drives every undriven pin from the bench. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top;
    import gpm_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, rmw = 0, xen = 0, wpo = 0, en = 0;
    gpm_addr_t addr = 8'h00;
    gpm_byte_t wd = 8'h00, rdq;
    gpm_byte_t tw[2] = '{8'h00, 8'h00}, xs[2] = '{8'h00, 8'h00}, xd[2] = '{8'h00, 8'h00};
    gpm_byte_t ext[2] = '{8'h00, 8'h00}, pin[2];
    logic [7:0] out_s[2], oe_s[2], pu_s[2], an_s[2], byp_s[2];
    logic irq, wake;
    gpm_byte_t lat[2], drv[2], knd[2], sel[2], val[2], byp[2], e_oe, d, pv, rv;
    int mismatches = 0, cmp_count = 0, cycles = 0, seed = 32'h7c04acb3, m;
    const gpm_addr_t A[6][2] = '{'{ADDR_P0_DATA, ADDR_P1_DATA}, '{ADDR_P0_DRIVE, ADDR_P1_DRIVE},
        '{ADDR_P0_KIND, ADDR_P1_KIND}, '{ADDR_P0_SELECT, ADDR_P1_SELECT},
        '{ADDR_P0_VALUE, ADDR_P1_VALUE}, '{ADDR_P0_BYPASS, ADDR_P1_BYPASS}};
    const gpm_byte_t RV[6] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
    gpm_port_io dut_u (.clk(clk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wd),
        .sfr_rd(rd), .sfr_rmw(rmw), .sfr_rdata_q(rdq), .xbar_enable(xen),
        .weak_pullup_off(wpo), .p0_xbar_sel(xs[0]), .p0_xbar_data(xd[0]), .p0_twowire(tw[0]),
        .p1_xbar_sel(xs[1]), .p1_xbar_data(xd[1]), .p1_twowire(tw[1]),
        .p0_bypass_q(byp_s[0]), .p1_bypass_q(byp_s[1]), .p0_pin_in(pin[0]),
        .p0_pin_out_q(out_s[0]), .p0_pin_oe_q(oe_s[0]), .p0_pullup_q(pu_s[0]),
        .p0_analog_q(an_s[0]), .p1_pin_in(pin[1]), .p1_pin_out_q(out_s[1]),
        .p1_pin_oe_q(oe_s[1]), .p1_pullup_q(pu_s[1]), .p1_analog_q(an_s[1]),
        .match_interrupt_enable(en), .match_irq_q(irq), .match_wake_q(wake));
    for (genvar g = 0; g < 2; g++) begin : g_pad
        gpm_pin_model u_pad (.clk(clk), .out(out_s[g]), .oe(oe_s[g]), .pu(pu_s[g]),
            .ext(ext[g]), .ext_en(8'hff), .pin(pin[g]));
    end
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // ************************************************************
    // Bus tasks and expectations
    // ************************************************************
    task automatic wr_reg(input gpm_addr_t a, input gpm_byte_t v);
        @(negedge clk) {wr, addr, wd} = {1'b1, a, v};
        @(negedge clk) wr = 0;
    endtask
    task automatic rd_reg(input gpm_addr_t a, input logic r, output gpm_byte_t v);
        @(negedge clk) {rd, rmw, addr} = {1'b1, r, a};
        @(negedge clk) {rd, rmw} = 2'b00;
        v = rdq;
    endtask
    function automatic gpm_byte_t exp_oe(int p, gpm_byte_t dd);
        return xen ? knd[p] & ((drv[p] & ~tw[p]) | ~dd) : 8'h00;
    endfunction
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        for (int k = 0; k < 6; k++) begin
            for (int p = 0; p < 2; p++) begin
                rd_reg(A[k][p], 1'b1, pv);
                `CHK("reset value", RV[k], pv)
            end
        end
        wr_reg(8'h81, 8'h5a);
        rd_reg(8'h81, 1'b0, pv);
        `CHK("unmapped", RD_UNMAPPED, pv)
        for (int i = 0; i < 40; i++) begin
            @(negedge clk) {xen, wpo, en} = $random(seed) & ((i == 1) ? 3'b011 : 3'b111);
            for (int p = 0; p < 2; p++) begin
                {lat[p], drv[p], knd[p], sel[p]} = $random(seed);
                {val[p], byp[p], tw[p], xs[p]} = $random(seed);
                {xd[p], ext[p]} = $random(seed);
                if (i == 0) sel[p] = 8'h00;
                if (i == 1) sel[p] = 8'hff;
                if (i == 1) ext[p] = val[p];
                if (i == 2) byp[p] = ~knd[p];
                wr_reg(A[0][p], lat[p]);
                wr_reg(A[1][p], drv[p]);
                wr_reg(A[2][p], knd[p]);
                wr_reg(A[3][p], sel[p]);
                wr_reg(A[4][p], val[p]);
                wr_reg(A[5][p], byp[p]);
            end
            repeat (8) @(negedge clk);
            m = 0;
            for (int p = 0; p < 2; p++) begin
                d = (xs[p] & xd[p]) | (~xs[p] & lat[p]);
                e_oe = exp_oe(p, d);
                pv = (e_oe & d) | (~e_oe & ext[p]);
                `CHK("byp", byp[p], byp_s[p])
                `CHK("oe", e_oe, oe_s[p])
                `CHK("out", e_oe & d, oe_s[p] & out_s[p])
                `CHK("pullup", wpo ? 8'h00 : knd[p] & ~e_oe & ~(drv[p] & ~tw[p]), pu_s[p])
                `CHK("analog", ~knd[p], an_s[p])
                if ((((pv ^ val[p]) & sel[p]) != 8'h00)) m = 1;
                rd_reg(A[0][p], 1'b0, rv);
                `CHK("pin read", pv & knd[p], rv)
                rd_reg(A[0][p], 1'b1, rv);
                `CHK("latch read", lat[p], rv)
            end
            `CHK("wake", m[0], wake)
            `CHK("irq", m[0] & en, irq)
        end
        report_and_stop();
    end
endmodule // tb_top

//--- design/gpm_cmp_if.sv
/*
 * Carrier between the top and one port's synchroniser and comparator.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface gpm_cmp_if;
    import gpm_pkg::*;
    gpm_byte_t pins_raw;
    gpm_byte_t pins_sync;
    gpm_byte_t sel;
    gpm_byte_t value;
    logic      match;

    modport cmp (
        input  pins_raw,
        input  sel,
        input  value,
        output pins_sync,
        output match
    );
    modport ctl (
        output pins_raw,
        output sel,
        output value,
        input  pins_sync,
        input  match
    );
endinterface

//--- design/gpm_pkg.sv
/*
 * Shared constants for the two-port I/O configuration and match block:
 * register addresses, reset values, port width and filter depth.
 * Assumes an 8-bit special function register space on the CPU side.
 */
package gpm_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned SYNC_STAGES = 3;

    typedef logic [PORT_W-1:0] gpm_byte_t;
    typedef logic [ADDR_W-1:0] gpm_addr_t;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam gpm_addr_t ADDR_P0_DATA    = 8'h80;
    localparam gpm_addr_t ADDR_P1_DATA    = 8'h90;
    localparam gpm_addr_t ADDR_P0_DRIVE   = 8'ha4;
    localparam gpm_addr_t ADDR_P1_DRIVE   = 8'ha5;
    localparam gpm_addr_t ADDR_P1_SELECT  = 8'hbf;
    localparam gpm_addr_t ADDR_P0_SELECT  = 8'hc7;
    localparam gpm_addr_t ADDR_P1_VALUE   = 8'hcf;
    localparam gpm_addr_t ADDR_P0_BYPASS  = 8'hd4;
    localparam gpm_addr_t ADDR_P1_BYPASS  = 8'hd5;
    localparam gpm_addr_t ADDR_P0_VALUE   = 8'hd7;
    localparam gpm_addr_t ADDR_P0_KIND    = 8'hf1;
    localparam gpm_addr_t ADDR_P1_KIND    = 8'hf2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam gpm_byte_t RST_DATA   = 8'hff;
    localparam gpm_byte_t RST_DRIVE  = 8'h00;
    localparam gpm_byte_t RST_SELECT = 8'h00;
    localparam gpm_byte_t RST_VALUE  = 8'hff;
    localparam gpm_byte_t RST_BYPASS = 8'h00;
    localparam gpm_byte_t RST_KIND   = 8'hff;
    localparam gpm_byte_t RD_UNMAPPED = 8'h00;
    localparam gpm_byte_t ALL_ZERO   = 8'h00;

endpackage

//--- design/gpm_port_cmp.sv
/*
 * One port: three-stage pin synchroniser with agreement filter and the
 * masked compare that flags a match event.
 * Assumes pins_raw is asynchronous to clk and sel/value are registers.
 */
`timescale 1ns/1ns
module gpm_port_cmp (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Port side
    gpm_cmp_if.cmp    port
);
    import gpm_pkg::*;

    typedef struct packed {
        gpm_byte_t s1;
        gpm_byte_t s2;
        gpm_byte_t s3;
        gpm_byte_t stable;
        logic      match;
    } gpm_cmp_s;

    gpm_cmp_s st_q;
    gpm_cmp_s st_d;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d    = st_q;
        st_d.s1 = port.pins_raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < PORT_W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.stable[i] = st_q.s3[i];
            end
        end
        // Level event while masked pins differ from masked value
        st_d.match = ((st_q.stable & port.sel) != (port.value & port.sel));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{s1: RST_DATA, s2: RST_DATA, s3: RST_DATA,
                      stable: RST_DATA, match: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign port.pins_sync = st_q.stable;
    assign port.match     = st_q.match;

endmodule // gpm_port_cmp

//--- design/gpm_port_io.sv
/*
 * Configuration, data latches, pin drive and match event logic for two
 * 8-bit general purpose ports.
 * Assumes a single-cycle special function register port from the CPU,
 * a crossbar that supplies per-pin routing, and pads that resolve
 * output enable and weak pull-up.
 */
`timescale 1ns/1ns
module gpm_port_io (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Register port
    input  wire gpm_pkg::gpm_addr_t sfr_addr,
    input  wire logic            sfr_wr,
    input  wire gpm_pkg::gpm_byte_t sfr_wdata,
    input  wire logic            sfr_rd,
    input  wire logic            sfr_rmw,
    output gpm_pkg::gpm_byte_t   sfr_rdata_q,
    // Crossbar side
    input  wire logic            xbar_enable,
    input  wire logic            weak_pullup_off,
    input  wire gpm_pkg::gpm_byte_t p0_xbar_sel,
    input  wire gpm_pkg::gpm_byte_t p0_xbar_data,
    input  wire gpm_pkg::gpm_byte_t p0_twowire,
    input  wire gpm_pkg::gpm_byte_t p1_xbar_sel,
    input  wire gpm_pkg::gpm_byte_t p1_xbar_data,
    input  wire gpm_pkg::gpm_byte_t p1_twowire,
    output gpm_pkg::gpm_byte_t   p0_bypass_q,
    output gpm_pkg::gpm_byte_t   p1_bypass_q,
    // Port 0 pins
    input  wire gpm_pkg::gpm_byte_t p0_pin_in,
    output gpm_pkg::gpm_byte_t   p0_pin_out_q,
    output gpm_pkg::gpm_byte_t   p0_pin_oe_q,
    output gpm_pkg::gpm_byte_t   p0_pullup_q,
    output gpm_pkg::gpm_byte_t   p0_analog_q,
    // Port 1 pins
    input  wire gpm_pkg::gpm_byte_t p1_pin_in,
    output gpm_pkg::gpm_byte_t   p1_pin_out_q,
    output gpm_pkg::gpm_byte_t   p1_pin_oe_q,
    output gpm_pkg::gpm_byte_t   p1_pullup_q,
    output gpm_pkg::gpm_byte_t   p1_analog_q,
    // Match event
    input  wire logic            match_interrupt_enable,
    output logic                 match_irq_q,
    output logic                 match_wake_q
);
    import gpm_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        gpm_byte_t p0_data;
        gpm_byte_t p1_data;
        gpm_byte_t p0_drive;
        gpm_byte_t p1_drive;
        gpm_byte_t p0_kind;
        gpm_byte_t p1_kind;
        gpm_byte_t p0_bypass;
        gpm_byte_t p1_bypass;
        gpm_byte_t p0_select;
        gpm_byte_t p1_select;
        gpm_byte_t p0_value;
        gpm_byte_t p1_value;
        gpm_byte_t rdata;
        gpm_byte_t p0_out;
        gpm_byte_t p0_oe;
        gpm_byte_t p0_pu;
        gpm_byte_t p1_out;
        gpm_byte_t p1_oe;
        gpm_byte_t p1_pu;
        gpm_byte_t p0_an;
        gpm_byte_t p1_an;
        logic      irq;
        logic      wake;
    } gpm_top_s;

    localparam gpm_top_s RST_STATE = '{
        p0_data:   RST_DATA,   p1_data:   RST_DATA,
        p0_drive:  RST_DRIVE,  p1_drive:  RST_DRIVE,
        p0_kind:   RST_KIND,   p1_kind:   RST_KIND,
        p0_bypass: RST_BYPASS, p1_bypass: RST_BYPASS,
        p0_select: RST_SELECT, p1_select: RST_SELECT,
        p0_value:  RST_VALUE,  p1_value:  RST_VALUE,
        rdata:     RD_UNMAPPED,
        p0_out:    ALL_ZERO,   p0_oe:     ALL_ZERO,  p0_pu: ALL_ZERO,
        p1_out:    ALL_ZERO,   p1_oe:     ALL_ZERO,  p1_pu: ALL_ZERO,
        p0_an:     ALL_ZERO,   p1_an:     ALL_ZERO,
        irq:       1'b0,
        wake:      1'b0
    };

    gpm_top_s st_q;
    gpm_top_s st_d;

    // ************************************************************
    // Per-port synchroniser and comparator
    // ************************************************************
    gpm_cmp_if cmp0 ();
    gpm_cmp_if cmp1 ();

    assign cmp0.pins_raw = p0_pin_in;
    assign cmp0.sel      = st_q.p0_select;
    assign cmp0.value    = st_q.p0_value;
    assign cmp1.pins_raw = p1_pin_in;
    assign cmp1.sel      = st_q.p1_select;
    assign cmp1.value    = st_q.p1_value;

    gpm_port_cmp u_cmp0 (
        .clk  (clk),
        .rst  (rst),
        .port (cmp0.cmp)
    );

    gpm_port_cmp u_cmp1 (
        .clk  (clk),
        .rst  (rst),
        .port (cmp1.cmp)
    );

    // ************************************************************
    // Pin drive terms
    // ************************************************************
    gpm_byte_t p0_level;
    gpm_byte_t p1_level;
    gpm_byte_t p0_push;
    gpm_byte_t p1_push;
    gpm_byte_t p0_oe_d;
    gpm_byte_t p1_oe_d;
    gpm_byte_t p0_pu_d;
    gpm_byte_t p1_pu_d;

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            // Crossbar-routed signal replaces the latch on assigned pins
            assign p0_level[gi] = p0_xbar_sel[gi] ? p0_xbar_data[gi]
                                                  : st_q.p0_data[gi];
            assign p1_level[gi] = p1_xbar_sel[gi] ? p1_xbar_data[gi]
                                                  : st_q.p1_data[gi];
            // Push-pull only on digital pins not carrying the two-wire bus
            assign p0_push[gi] = st_q.p0_drive[gi] & st_q.p0_kind[gi]
                                 & ~p0_twowire[gi];
            assign p1_push[gi] = st_q.p1_drive[gi] & st_q.p1_kind[gi]
                                 & ~p1_twowire[gi];
            // Open-drain drives only a low; analog pins never drive
            assign p0_oe_d[gi] = xbar_enable & st_q.p0_kind[gi]
                                 & (p0_push[gi] | ~p0_level[gi]);
            assign p1_oe_d[gi] = xbar_enable & st_q.p1_kind[gi]
                                 & (p1_push[gi] | ~p1_level[gi]);
            // Weak pull-up on digital open-drain pins not driving low
            assign p0_pu_d[gi] = ~weak_pullup_off & st_q.p0_kind[gi]
                                 & ~p0_push[gi] & ~p0_oe_d[gi];
            assign p1_pu_d[gi] = ~weak_pullup_off & st_q.p1_kind[gi]
                                 & ~p1_push[gi] & ~p1_oe_d[gi];
        end
    endgenerate

    // ************************************************************
    // Register read data
    // ************************************************************
    gpm_byte_t rd_mux;

    always_comb begin
        rd_mux = RD_UNMAPPED;
        case (sfr_addr)
            ADDR_P0_DATA: begin
                // Receiver off on analog pins, so they read as 0
                rd_mux = sfr_rmw ? st_q.p0_data
                                 : (cmp0.pins_sync & st_q.p0_kind);
            end
            ADDR_P1_DATA: begin
                rd_mux = sfr_rmw ? st_q.p1_data
                                 : (cmp1.pins_sync & st_q.p1_kind);
            end
            ADDR_P0_DRIVE:  rd_mux = st_q.p0_drive;
            ADDR_P1_DRIVE:  rd_mux = st_q.p1_drive;
            ADDR_P0_KIND:   rd_mux = st_q.p0_kind;
            ADDR_P1_KIND:   rd_mux = st_q.p1_kind;
            ADDR_P0_BYPASS: rd_mux = st_q.p0_bypass;
            ADDR_P1_BYPASS: rd_mux = st_q.p1_bypass;
            ADDR_P0_SELECT: rd_mux = st_q.p0_select;
            ADDR_P1_SELECT: rd_mux = st_q.p1_select;
            ADDR_P0_VALUE:  rd_mux = st_q.p0_value;
            ADDR_P1_VALUE:  rd_mux = st_q.p1_value;
            default:        rd_mux = RD_UNMAPPED;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_P0_DATA:   st_d.p0_data   = sfr_wdata;
                ADDR_P1_DATA:   st_d.p1_data   = sfr_wdata;
                ADDR_P0_DRIVE:  st_d.p0_drive  = sfr_wdata;
                ADDR_P1_DRIVE:  st_d.p1_drive  = sfr_wdata;
                ADDR_P0_KIND:   st_d.p0_kind   = sfr_wdata;
                ADDR_P1_KIND:   st_d.p1_kind   = sfr_wdata;
                ADDR_P0_BYPASS: st_d.p0_bypass = sfr_wdata;
                ADDR_P1_BYPASS: st_d.p1_bypass = sfr_wdata;
                ADDR_P0_SELECT: st_d.p0_select = sfr_wdata;
                ADDR_P1_SELECT: st_d.p1_select = sfr_wdata;
                ADDR_P0_VALUE:  st_d.p0_value  = sfr_wdata;
                ADDR_P1_VALUE:  st_d.p1_value  = sfr_wdata;
                default: begin
                end
            endcase
        end
        if (sfr_rd) begin
            st_d.rdata = rd_mux;
        end
        st_d.p0_out = p0_level;
        st_d.p0_oe  = p0_oe_d;
        st_d.p0_pu  = p0_pu_d;
        st_d.p1_out = p1_level;
        st_d.p1_oe  = p1_oe_d;
        st_d.p1_pu  = p1_pu_d;
        // Analog flags registered alongside the drive terms so they change together
        st_d.p0_an  = ~st_q.p0_kind;
        st_d.p1_an  = ~st_q.p1_kind;
        // Wake needs no enable; interrupt request is gated
        st_d.wake = cmp0.match | cmp1.match;
        st_d.irq  = (cmp0.match | cmp1.match) & match_interrupt_enable;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= RST_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign sfr_rdata_q  = st_q.rdata;
    assign p0_bypass_q  = st_q.p0_bypass;
    assign p1_bypass_q  = st_q.p1_bypass;
    assign p0_pin_out_q = st_q.p0_out;
    assign p0_pin_oe_q  = st_q.p0_oe;
    assign p0_pullup_q  = st_q.p0_pu;
    assign p0_analog_q  = st_q.p0_an;
    assign p1_pin_out_q = st_q.p1_out;
    assign p1_pin_oe_q  = st_q.p1_oe;
    assign p1_pullup_q  = st_q.p1_pu;
    assign p1_analog_q  = st_q.p1_an;
    assign match_irq_q  = st_q.irq;
    assign match_wake_q = st_q.wake;

endmodule // gpm_port_io
